// ===== swcfg_pkg.sv
// Constants, register map and carrier types of the switch config latch.
// Assumes a single 20 MHz clock domain shared by every user of the package.
package swcfg_pkg;

	// ============================================================
	// Timing
	localparam int CLK_HZ       = 20_000_000;
	localparam int DEB_TIME_MS  = 5;
	localparam int DEB_CYC      = CLK_HZ / 1000 * DEB_TIME_MS;
	localparam int STEP_TIME_MS = 1000;
	localparam int STEP_CYC     = CLK_HZ / 1000 * STEP_TIME_MS;
	localparam int SCAN_TIME_MS = 2000;
	localparam int SCAN_CYC     = CLK_HZ / 1000 * SCAN_TIME_MS;

	// ============================================================
	// Channels and addresses
	localparam int         NUM_CH      = 8;
	localparam logic [3:0] LOCAL_COUNT = 4'h2;
	localparam logic [6:0] ADDR_BAD    = 7'h7e;
	localparam logic [6:0] ADDR_CLEAR  = 7'h7f;
	localparam logic [2:0] LOCAL_CH_AI1 = 3'h0;
	localparam logic [2:0] LOCAL_CH_AI2 = 3'h1;
	localparam logic [3:0] STAT_OK      = 4'h0;
	localparam logic [3:0] STAT_CFG_ERR = 4'h1;

	// ============================================================
	// Register map
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STAT    = 8'h04;
	localparam logic [2:0] REG_CH_PAGE  = 3'h1;
	localparam logic [2:0] REG_VAL_PAGE = 3'h2;
	localparam logic [3:0] CTRL_COUNT_RST = 4'h8;
	localparam logic       CTRL_BAR_RST   = 1'h1;
	localparam int CTRL_BAR_BIT = 4;
	localparam int CH_OFF_LSB   = 8;
	localparam int CH_OFFEN_BIT = 15;
	localparam int CH_IDX_LSB   = 16;
	localparam int CH_EN_BIT    = 24;
	localparam int CH_ERR_BIT   = 25;

	// ============================================================
	// Carriers
	typedef struct packed {
		logic       set;
		logic       addr_mode;
		logic       ai1;
		logic       local_src;
		logic       wlock;
		logic [6:0] val;
	} swcfg_sw_t;

	typedef struct packed {
		logic       en;
		logic       err;
		logic       off_en;
		logic [6:0] addr;
		logic [6:0] off;
		logic [3:0] idx;
	} swcfg_ch_t;

	typedef struct packed {
		logic        valid;
		logic [6:0]  addr;
		logic [6:0]  off;
		logic [3:0]  idx;
		logic [15:0] data;
	} swcfg_rx_t;

	typedef enum logic [2:0] {
		PU_SEG_ON  = 3'b000,
		PU_SEG_OFF = 3'b001,
		PU_MAKER   = 3'b011,
		PU_DEVICE  = 3'b010,
		PU_FW      = 3'b110,
		PU_REV     = 3'b111,
		PU_RUN     = 3'b101,
		PU_FAIL    = 3'b100
	} swcfg_pu_t;

endpackage : swcfg_pkg

// ===== swcfg_top.sv
// Switch configuration latch, power-up display sequencer and channel
// source selection of a listen-only fieldbus indicator.
// Assumes a frame decoder on clk feeding rx and source events, and a
// classic Wishbone master for the remote tool path via the service port.
//
// Behaviour
// - Local switch mode shows only two display values.
// - Local switch mode hides the bargraph.
// - Remote mode ignores every switch except write protect.
// - Local mode enables all switches and refuses remote tool writes.
// - Channel selector routes to input 1 when on, input 2 when off.
// - Address mode reads switches 1..64 as source address 0..125.
// - Settings accepted only on set switch off-to-on edge.
// - Set switch already on at power-up accepts nothing.
// - Write protect blocks set switch edges.
// - Address 127 clears and disables the selected channel.
// - Address 126 is not used and flags a configuration error.
// - Offset mode takes a byte index 0..127 of the source data.
// - Power-up shows segments on, off, maker, device, firmware, rev.
// - Failed power-up shows the matching status message.
// - After power-up enter normal indicating mode.
// - Device only listens; never transmits or claims an address.
// - Each of eight channels holds its own source address.
// - A channel shows the first published value by default.
// - Further values of a source can be chosen manually.
// - Bus reconfiguration or lost source flags a channel error.
// - Lost displayed value moves channel to next value.
// - Write protect rejects all changes and lights the padlock.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module swcfg_top #(
	parameter int DEB_CYC  = swcfg_pkg::DEB_CYC,
	parameter int STEP_CYC = swcfg_pkg::STEP_CYC,
	parameter int SCAN_CYC = swcfg_pkg::SCAN_CYC
) (
	input  wire logic                 clk,           // 20 MHz clock
	input  wire logic                 srst,          // Sync reset
	input  wire swcfg_pkg::swcfg_sw_t sw_pins,       // Raw switches
	input  wire swcfg_pkg::swcfg_rx_t rx,            // Captured value
	input  wire logic                 bus_reconfig,  // Bus reconfigured
	input  wire logic                 src_lost,      // Source vanished
	input  wire logic [6:0]           src_lost_addr, // Its address
	input  wire logic                 val_lost,      // Value vanished
	input  wire logic [6:0]           val_lost_addr, // Its address
	input  wire logic [3:0]           val_lost_idx,  // Its index
	input  wire logic                 selftest_done, // Self test over
	input  wire logic                 selftest_fail, // Self test failed
	input  wire logic [3:0]           fail_code,     // Failure cause
	input  wire logic                 wb_cyc,        // Wishbone cycle
	input  wire logic                 wb_stb,        // Wishbone strobe
	input  wire logic                 wb_we,         // Write enable
	input  wire logic [7:0]           wb_adr,        // Byte address
	input  wire logic [3:0]           wb_sel,        // Byte lanes
	input  wire logic [31:0]          wb_dat_w,      // Write data
	output      logic [31:0]          wb_dat_r,      // Read data
	output      logic                 wb_ack,        // Acknowledge
	output      swcfg_pkg::swcfg_pu_t disp_phase,    // Display phase
	output      logic [3:0]           disp_status,   // Status message
	output      logic [15:0]          disp_value,    // Shown value
	output      logic [2:0]           disp_chan,     // Shown channel
	output      logic [3:0]           disp_count,    // Visible values
	output      logic                 bargraph_on,   // Bargraph enable
	output      logic                 padlock_on     // Padlock symbol
);

	// ============================================================
	// Switch synchroniser and debounce
	swcfg_pkg::swcfg_sw_t meta_r, sync_r, cand_r, deb_r;
	logic [31:0]          deb_cnt_r;
	logic                 deb_ok_r;

	always_ff @(posedge clk) begin
		meta_r <= sw_pins;
		sync_r <= meta_r;
	end

	// Whole vector must hold still for the debounce time
	always_ff @(posedge clk) begin
		if (srst) begin
			cand_r    <= '0;
			deb_r     <= '0;
			deb_cnt_r <= 32'h0;
			deb_ok_r  <= 1'b0;
		end else if (sync_r != cand_r) begin
			cand_r    <= sync_r;
			deb_cnt_r <= 32'h0;
		end else if (deb_cnt_r == 32'(DEB_CYC - 1)) begin
			deb_r    <= cand_r;
			deb_ok_r <= 1'b1;
		end else begin
			deb_cnt_r <= deb_cnt_r + 32'h1;
		end
	end

	// ============================================================
	// Set edge detection
	logic set_prev_r, armed_r;
	logic loc_mode, loc_wr;
	logic [2:0] loc_ch;

	// Armed only after the set switch is seen off once
	always_ff @(posedge clk) begin
		if (srst) begin
			set_prev_r <= 1'b1;
			armed_r    <= 1'b0;
		end else if (deb_ok_r) begin
			set_prev_r <= deb_r.set;
			if (!deb_r.set) begin
				armed_r <= 1'b1;
			end
		end
	end

	assign loc_mode = deb_r.local_src;
	assign loc_wr = armed_r && deb_r.set && !set_prev_r &&
		loc_mode && !deb_r.wlock;
	assign loc_ch = deb_r.ai1 ? swcfg_pkg::LOCAL_CH_AI1 :
		swcfg_pkg::LOCAL_CH_AI2;

	// a_set_edge_only: acceptance needs a debounced off-to-on edge
	a_set_edge_only: assert property (@(posedge clk) disable iff (srst)
		loc_wr |-> deb_r.set && $past(deb_r.set, 2) == 1'b0 ||
		deb_r.set && !set_prev_r)
		else $error("set accepted without an edge");
	a_pwr_on_set: assert property (@(posedge clk) disable iff (srst)
		!armed_r |-> !loc_wr)
		else $error("set accepted before switch seen off");
	a_remote_ignore: assert property (@(posedge clk) disable iff (srst)
		!loc_mode |-> !loc_wr)
		else $error("switch accepted in remote mode");

	// ============================================================
	// Wishbone slave
	logic        wb_req, rem_ok, rem_wr, ctrl_bar_r;
	logic [3:0]  ctrl_count_r;
	logic [31:0] rd_nxt, wmask;

	assign wb_req = wb_cyc && wb_stb && !wb_ack;
	assign rem_ok = !loc_mode && !deb_r.wlock;
	assign rem_wr = wb_req && wb_we && rem_ok;
	assign wmask  = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
		{8{wb_sel[1]}}, {8{wb_sel[0]}}};

	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack <= 1'b0;
		end else begin
			wb_ack <= wb_req;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_count_r <= swcfg_pkg::CTRL_COUNT_RST;
			ctrl_bar_r   <= swcfg_pkg::CTRL_BAR_RST;
		end else if (rem_wr && wb_adr == swcfg_pkg::REG_CTRL &&
			wb_sel[0]) begin
			ctrl_count_r <= wb_dat_w[3:0];
			ctrl_bar_r   <= wb_dat_w[swcfg_pkg::CTRL_BAR_BIT];
		end
	end

	a_remote_refuse: assert property (@(posedge clk) disable iff (srst)
		loc_mode || deb_r.wlock |-> !rem_wr)
		else $error("remote write taken while refused");

	// ============================================================
	// Channel table, one entry per display channel
	swcfg_pkg::swcfg_ch_t chan_r [swcfg_pkg::NUM_CH];
	logic [15:0]          val_r  [swcfg_pkg::NUM_CH];

	genvar gi;
	for (gi = 0; gi < swcfg_pkg::NUM_CH; gi++) begin : g_ch
		swcfg_pkg::swcfg_ch_t ch_nxt;
		logic [31:0]          ch_word, ch_new;
		logic                 rem_hit, loc_hit;

		assign rem_hit = rem_wr && wb_adr[7:5] == swcfg_pkg::REG_CH_PAGE &&
			wb_adr[4:2] == 3'(gi) && wb_adr[1:0] == 2'h0;
		assign loc_hit = loc_wr && loc_ch == 3'(gi);
		assign ch_word = {6'h0, chan_r[gi].err, chan_r[gi].en,
			4'h0, chan_r[gi].idx, chan_r[gi].off_en, chan_r[gi].off,
			1'b0, chan_r[gi].addr};
		assign ch_new  = (ch_word & ~wmask) | (wb_dat_w & wmask);

		always_comb begin
			ch_nxt = chan_r[gi];
			if (loc_hit && deb_r.addr_mode) begin
				ch_nxt.addr = deb_r.val;
				ch_nxt.idx  = 4'h0;
				ch_nxt.en   = 1'b1;
				ch_nxt.err  = 1'b0;
			end else if (loc_hit) begin
				ch_nxt.off    = deb_r.val;
				ch_nxt.off_en = 1'b1;
			end else if (rem_hit) begin
				ch_nxt.addr   = ch_new[6:0];
				ch_nxt.off    = ch_new[swcfg_pkg::CH_OFF_LSB +: 7];
				ch_nxt.off_en = ch_new[swcfg_pkg::CH_OFFEN_BIT];
				ch_nxt.idx    = ch_new[swcfg_pkg::CH_IDX_LSB +: 4];
				ch_nxt.en     = ch_new[swcfg_pkg::CH_EN_BIT];
				ch_nxt.err    = 1'b0;
			end
			if ((loc_hit && deb_r.addr_mode) || rem_hit) begin
				if (ch_nxt.addr == swcfg_pkg::ADDR_CLEAR) begin
					ch_nxt = '0;
					ch_nxt.addr = swcfg_pkg::ADDR_CLEAR;
				end else if (ch_nxt.addr == swcfg_pkg::ADDR_BAD) begin
					ch_nxt.en  = 1'b0;
					ch_nxt.err = 1'b1;
				end
			end
			// Event after a write in the same cycle still wins
			if (chan_r[gi].en && (bus_reconfig ||
				(src_lost && src_lost_addr == chan_r[gi].addr))) begin
				ch_nxt.err = 1'b1;
			end else if (val_lost && chan_r[gi].en && !chan_r[gi].off_en &&
				val_lost_addr == chan_r[gi].addr &&
				val_lost_idx == chan_r[gi].idx) begin
				ch_nxt.idx = chan_r[gi].idx + 4'h1;
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				chan_r[gi] <= '0;
			end else begin
				chan_r[gi] <= ch_nxt;
			end
		end

		// Only received frames are ever consumed here
		always_ff @(posedge clk) begin
			if (srst) begin
				val_r[gi] <= 16'h0;
			end else if (rx.valid && chan_r[gi].en && !chan_r[gi].err &&
				rx.addr == chan_r[gi].addr &&
				(chan_r[gi].off_en ? rx.off == chan_r[gi].off :
				rx.idx == chan_r[gi].idx)) begin
				val_r[gi] <= rx.data;
			end
		end
	end

	a_clear_127: assert property (@(posedge clk) disable iff (srst)
		loc_wr && deb_r.addr_mode && deb_r.ai1 &&
		deb_r.val == swcfg_pkg::ADDR_CLEAR |=> !chan_r[0].en)
		else $error("address 127 did not disable channel");
	a_err_126: assert property (@(posedge clk) disable iff (srst)
		loc_wr && deb_r.addr_mode && !deb_r.ai1 &&
		deb_r.val == swcfg_pkg::ADDR_BAD |=> chan_r[1].err && !chan_r[1].en)
		else $error("address 126 not flagged");
	a_next_value: assert property (@(posedge clk) disable iff (srst)
		val_lost && !bus_reconfig && !src_lost && !wb_cyc && !loc_wr &&
		chan_r[2].en && !chan_r[2].off_en &&
		val_lost_addr == chan_r[2].addr && val_lost_idx == chan_r[2].idx
		|=> chan_r[2].idx == $past(chan_r[2].idx) + 4'h1)
		else $error("channel did not move to next value");

	// ============================================================
	// Register read
	always_comb begin
		rd_nxt = 32'h0;
		if (wb_adr == swcfg_pkg::REG_CTRL) begin
			rd_nxt = {27'h0, ctrl_bar_r, ctrl_count_r};
		end else if (wb_adr == swcfg_pkg::REG_STAT) begin
			rd_nxt[11:0]  = deb_r;
			rd_nxt[14:12] = disp_phase;
			rd_nxt[15]    = armed_r;
			for (int k = 0; k < swcfg_pkg::NUM_CH; k++) begin
				rd_nxt[16 + k] = chan_r[k].err;
			end
		end else if (wb_adr[1:0] == 2'h0 &&
			wb_adr[7:5] == swcfg_pkg::REG_CH_PAGE) begin
			rd_nxt = {6'h0, chan_r[wb_adr[4:2]].err,
				chan_r[wb_adr[4:2]].en, 4'h0, chan_r[wb_adr[4:2]].idx,
				chan_r[wb_adr[4:2]].off_en, chan_r[wb_adr[4:2]].off,
				1'b0, chan_r[wb_adr[4:2]].addr};
		end else if (wb_adr[1:0] == 2'h0 &&
			wb_adr[7:5] == swcfg_pkg::REG_VAL_PAGE) begin
			rd_nxt = {16'h0, val_r[wb_adr[4:2]]};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wb_dat_r <= 32'h0;
		end else if (wb_req && !wb_we) begin
			wb_dat_r <= rd_nxt;
		end
	end

	// ============================================================
	// Power-up display sequence
	swcfg_pkg::swcfg_pu_t pu_nxt;
	logic [31:0]          step_cnt_r;
	logic                 step_end;

	assign step_end = step_cnt_r == 32'(STEP_CYC - 1);

	always_comb begin
		pu_nxt = disp_phase;
		case (disp_phase)
			swcfg_pkg::PU_SEG_ON: begin
				if (step_end) pu_nxt = swcfg_pkg::PU_SEG_OFF;
			end
			swcfg_pkg::PU_SEG_OFF: begin
				if (step_end) pu_nxt = swcfg_pkg::PU_MAKER;
			end
			swcfg_pkg::PU_MAKER: begin
				if (step_end) pu_nxt = swcfg_pkg::PU_DEVICE;
			end
			swcfg_pkg::PU_DEVICE: begin
				if (step_end) pu_nxt = swcfg_pkg::PU_FW;
			end
			swcfg_pkg::PU_FW: begin
				if (step_end) pu_nxt = swcfg_pkg::PU_REV;
			end
			swcfg_pkg::PU_REV: begin
				// Holds on revision until self test reports
				if (step_end && selftest_done) begin
					pu_nxt = selftest_fail ? swcfg_pkg::PU_FAIL :
						swcfg_pkg::PU_RUN;
				end
			end
			swcfg_pkg::PU_RUN:  pu_nxt = swcfg_pkg::PU_RUN;
			swcfg_pkg::PU_FAIL: pu_nxt = swcfg_pkg::PU_FAIL;
			default: pu_nxt = swcfg_pkg::PU_SEG_ON;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			disp_phase <= swcfg_pkg::PU_SEG_ON;
			step_cnt_r <= 32'h0;
		end else begin
			disp_phase <= pu_nxt;
			if (pu_nxt != disp_phase || step_end) begin
				step_cnt_r <= 32'h0;
			end else begin
				step_cnt_r <= step_cnt_r + 32'h1;
			end
		end
	end

	a_pu_order: assert property (@(posedge clk) disable iff (srst)
		disp_phase == swcfg_pkg::PU_SEG_ON |=>
		disp_phase inside {swcfg_pkg::PU_SEG_ON, swcfg_pkg::PU_SEG_OFF})
		else $error("power-up order broken");
	a_pu_fail: assert property (@(posedge clk) disable iff (srst)
		disp_phase == swcfg_pkg::PU_REV && step_end && selftest_done &&
		selftest_fail |=> disp_phase == swcfg_pkg::PU_FAIL ##1
		disp_status == $past(fail_code))
		else $error("failure status not shown");

	// ============================================================
	// Indicating mode: scan of visible channels
	logic [31:0] scan_cnt_r;
	logic [3:0]  vis_cnt;

	assign vis_cnt = loc_mode ? swcfg_pkg::LOCAL_COUNT : ctrl_count_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			scan_cnt_r <= 32'h0;
			disp_chan  <= 3'h0;
		end else if (disp_phase != swcfg_pkg::PU_RUN) begin
			scan_cnt_r <= 32'h0;
		end else if (scan_cnt_r == 32'(SCAN_CYC - 1) ||
			{1'b0, disp_chan} >= vis_cnt) begin
			scan_cnt_r <= 32'h0;
			// Wraps early when the visible count shrinks
			if ({1'b0, disp_chan} + 4'h1 >= vis_cnt) begin
				disp_chan <= 3'h0;
			end else begin
				disp_chan <= disp_chan + 3'h1;
			end
		end else begin
			scan_cnt_r <= scan_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			disp_value  <= 16'h0;
			disp_status <= swcfg_pkg::STAT_OK;
			disp_count  <= swcfg_pkg::CTRL_COUNT_RST;
			bargraph_on <= 1'b0;
			padlock_on  <= 1'b0;
		end else begin
			disp_value  <= val_r[disp_chan];
			disp_count  <= vis_cnt;
			bargraph_on <= ctrl_bar_r && !loc_mode;
			padlock_on  <= deb_r.wlock;
			if (disp_phase == swcfg_pkg::PU_FAIL) begin
				disp_status <= fail_code;
			end else if (chan_r[disp_chan].err) begin
				disp_status <= swcfg_pkg::STAT_CFG_ERR;
			end else begin
				disp_status <= swcfg_pkg::STAT_OK;
			end
		end
	end

	a_local_two: assert property (@(posedge clk) disable iff (srst)
		$past(loc_mode) |-> disp_count == swcfg_pkg::LOCAL_COUNT)
		else $error("local mode shows other than two");
	a_bar_hidden: assert property (@(posedge clk) disable iff (srst)
		$past(loc_mode) |-> !bargraph_on)
		else $error("bargraph shown in local mode");
	a_padlock_lit: assert property (@(posedge clk) disable iff (srst)
		deb_r.wlock |-> !loc_wr && !rem_wr ##1 padlock_on)
		else $error("write protect not honoured");

endmodule : swcfg_top

// ===== swcfg_src_model.sv
// Behavioural model of the measuring stations publishing on the fieldbus.
// Assumes the bench raises req.valid for one clk cycle per event.
`timescale 1ns/1ps

module swcfg_src_model (
	input  wire logic                 clk,           // 20 MHz clock
	input  wire logic                 srst,          // Sync reset
	input  wire logic [1:0]           kind,          // 0 pub,1 val,2 src
	input  wire swcfg_pkg::swcfg_rx_t req,           // Event request
	output      swcfg_pkg::swcfg_rx_t rx,            // Captured value
	output      logic                 src_lost,      // Station gone
	output      logic [6:0]           src_lost_addr, // Its address
	output      logic                 val_lost,      // Value gone
	output      logic [6:0]           val_lost_addr, // Its address
	output      logic [3:0]           val_lost_idx   // Its index
);
	logic [15:0] junk_r;
	logic        go;

	assign go = req.valid;

	// ============================================================
	// Idle pattern
	// Fields churn between events so a stale value never matches
	always_ff @(posedge clk) begin
		if (srst) begin
			junk_r <= 16'h0001;
		end else begin
			junk_r <= {junk_r[14:0], ~junk_r[15]};
		end
	end

	// ============================================================
	// Events
	always_ff @(posedge clk) begin
		if (srst) begin
			rx       <= '0;
			src_lost <= 1'b0;
			val_lost <= 1'b0;
		end else begin
			rx.valid      <= go && (kind == 2'h0);
			rx.addr       <= go ? req.addr : junk_r[6:0];
			rx.off        <= go ? {req.idx, 3'h0} : junk_r[9:3];
			rx.idx        <= go ? req.idx : junk_r[10:7];
			rx.data       <= go ? req.data : ~junk_r;
			src_lost      <= go && (kind == 2'h2);
			src_lost_addr <= go ? req.addr : junk_r[13:7];
			val_lost      <= go && (kind == 2'h1);
			val_lost_addr <= go ? req.addr : junk_r[8:2];
			val_lost_idx  <= go ? req.idx : junk_r[3:0];
		end
	end
endmodule : swcfg_src_model

// ===== testbench.sv
// Self-checking bench of the switch config latch.
// Assumes swcfg_pkg, swcfg_top and swcfg_src_model compiled before it.
`timescale 1ns/1ps

module testbench;
	localparam int SETTLE = 12;
	localparam int LIMIT  = 20000;

	logic                 clk = 1'b0, srst = 1'b1;
	swcfg_pkg::swcfg_sw_t sw_pins = '0;
	swcfg_pkg::swcfg_rx_t rx, m_req = '0;
	logic [1:0]           m_kind = 2'h0;
	logic                 bus_reconfig = 1'b0, src_lost, val_lost;
	logic [6:0]           src_lost_addr, val_lost_addr;
	logic [3:0]           val_lost_idx, fail_code = 4'h9, wb_sel = 4'h0;
	logic                 selftest_done = 1'b1, selftest_fail = 1'b1;
	logic                 wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]           wb_adr = 8'h00;
	logic [31:0]          wb_dat_w = 32'h0, wb_dat_r;
	logic                 wb_ack, bargraph_on, padlock_on;
	swcfg_pkg::swcfg_pu_t disp_phase;
	logic [3:0]           disp_status, disp_count;
	logic [15:0]          disp_value;
	logic [2:0]           disp_chan;
	int                   fails = 0, n_tests = 0, cyc_cnt = 0;

	always #25 clk = ~clk;

	swcfg_top #(.DEB_CYC(4), .STEP_CYC(8), .SCAN_CYC(16)) dut (.clk, .srst,
		.sw_pins, .rx, .bus_reconfig, .src_lost, .src_lost_addr, .val_lost,
		.val_lost_addr, .val_lost_idx, .selftest_done, .selftest_fail,
		.fail_code, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
		.wb_dat_r, .wb_ack, .disp_phase, .disp_status, .disp_value,
		.disp_chan, .disp_count, .bargraph_on, .padlock_on);

	swcfg_src_model src (.clk, .srst, .kind(m_kind), .req(m_req), .rx,
		.src_lost, .src_lost_addr, .val_lost, .val_lost_addr, .val_lost_idx);

	// ============================================================
	// Helpers
	task automatic tally_and_finish();
		if (fails == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == LIMIT) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= adr;
		wb_sel   <= 4'hf;
		wb_dat_w <= wd;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (wb_ack === 1'b1) break;
		end
		rd = wb_dat_r;
		chk({31'h0, wb_ack}, 32'h1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] dummy;
		wb(1'b1, adr, d, dummy);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask,
		input logic [31:0] exp);
		logic [31:0] d;
		wb(1'b0, adr, 32'h0, d);
		chk(d & mask, exp);
	endtask : rd_chk

	// Go: 0 only sets levels, 1 full press, 2 bounce shorter than debounce
	task automatic set_sw(input logic [1:0] go, input logic loc,
		input logic am, input logic a1, input logic wl, input logic [6:0] v);
		@(posedge clk);
		sw_pins <= {1'b0, am, a1, loc, wl, v};
		repeat (SETTLE) @(posedge clk);
		if (go != 2'h0) begin
			sw_pins.set <= 1'b1;
			repeat (go == 2'h1 ? SETTLE : 2) @(posedge clk);
			sw_pins.set <= 1'b0;
			repeat (SETTLE) @(posedge clk);
		end
	endtask : set_sw

	task automatic ev(input logic [1:0] k, input logic [6:0] a,
		input logic [3:0] i, input logic [15:0] d);
		@(posedge clk);
		m_kind <= k;
		m_req  <= {1'b1, a, 7'h00, i, d};
		@(posedge clk);
		m_req.valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : ev

	// ============================================================
	// Power-up sequence, bad expects the failing self test set by the caller
	task automatic powerup(input logic bad);
		swcfg_pkg::swcfg_pu_t seq [6];
		swcfg_pkg::swcfg_pu_t was;
		int k, n;
		seq = '{swcfg_pkg::PU_SEG_OFF, swcfg_pkg::PU_MAKER,
			swcfg_pkg::PU_DEVICE, swcfg_pkg::PU_FW, swcfg_pkg::PU_REV,
			bad ? swcfg_pkg::PU_FAIL : swcfg_pkg::PU_RUN};
		@(posedge clk);
		srst <= 1'b1;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		chk({29'h0, disp_phase}, {29'h0, swcfg_pkg::PU_SEG_ON});
		was = disp_phase;
		for (k = 0; k < 6; k++) begin
			if (k == 5 && !bad) begin
				repeat (20) @(posedge clk);
				chk({29'h0, disp_phase}, {29'h0, swcfg_pkg::PU_REV});
				selftest_done <= 1'b1;
			end
			for (n = 0; n < 64 && disp_phase === was; n++) @(posedge clk);
			was = disp_phase;
			chk({29'h0, was}, {29'h0, seq[k]});
		end
		// Status follows the phase by one register stage
		if (bad) begin
			@(posedge clk);
			chk({28'h0, disp_status}, {28'h0, fail_code});
		end
	endtask : powerup

	// ============================================================
	// Main sequence
	initial begin
		powerup(1'b1);
		selftest_fail <= 1'b0;
		selftest_done <= 1'b0;
		sw_pins       <= 12'hf30;
		powerup(1'b0);
		rd_chk(8'h20, 32'hffffffff, 32'h0);
		set_sw(2'h1, 1'b1, 1'b1, 1'b1, 1'b0, 7'h23);
		rd_chk(8'h20, 32'h807f, 32'h23);
		set_sw(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 7'h11);
		rd_chk(8'h24, 32'hff00, 32'h9100);
		rd_chk(8'h20, 32'h807f, 32'h23);
		wr(8'h00, 32'h13);
		rd_chk(8'h00, 32'h1f, 32'h18);
		chk({28'h0, disp_count}, 32'h2);
		chk({31'h0, bargraph_on}, 32'h0);
		set_sw(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 7'h05);
		rd_chk(8'h20, 32'h7f, 32'h23);
		chk({31'h0, padlock_on}, 32'h1);
		set_sw(2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h05);
		rd_chk(8'h20, 32'h7f, 32'h23);
		chk({28'h0, disp_count}, 32'h8);
		chk({31'h0, bargraph_on}, 32'h1);
		wr(8'h00, 32'h13);
		rd_chk(8'h00, 32'h1f, 32'h13);
		chk({28'h0, disp_count}, 32'h3);
		rd_chk(8'h80, 32'hffffffff, 32'h0);
		ev(2'h0, 7'h23, 4'h0, 16'h1234);
		rd_chk(8'h40, 32'hffff, 32'h1234);
		ev(2'h1, 7'h23, 4'h0, 16'h0);
		rd_chk(8'h20, 32'hf0000, 32'h10000);
		ev(2'h0, 7'h23, 4'h1, 16'habcd);
		rd_chk(8'h40, 32'hffff, 32'habcd);
		ev(2'h2, 7'h23, 4'h0, 16'h0);
		rd_chk(8'h20, 32'h2000000, 32'h2000000);
		wr(8'h20, 32'h1030023);
		rd_chk(8'h20, 32'h30f007f, 32'h1030023);
		ev(2'h0, 7'h23, 4'h3, 16'h5a5a);
		rd_chk(8'h40, 32'hffff, 32'h5a5a);
		@(posedge clk);
		bus_reconfig <= 1'b1;
		@(posedge clk);
		bus_reconfig <= 1'b0;
		rd_chk(8'h20, 32'h2000000, 32'h2000000);
		set_sw(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 7'h7e);
		rd_chk(8'h24, 32'h3000000, 32'h2000000);
		set_sw(2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 7'h44);
		rd_chk(8'h20, 32'h7f, 32'h23);
		set_sw(2'h1, 1'b1, 1'b1, 1'b1, 1'b0, 7'h7f);
		rd_chk(8'h20, 32'hffffffff, 32'h7f);
		tally_and_finish();
	end
endmodule : testbench
